/* File: logic/ataln_natmax_fmt.sv */
// formats the native maximum address into task-file bytes for the legacy command
`timescale 1ns/1ns
module ataln_natmax_fmt
   import ataln_pkg::*;
(
   input wire logic [47:0] native_max,
   input wire logic lba_mode,
   input wire logic [15:0] max_cyl,
   input wire logic [3:0] max_head,
   input wire logic [7:0] max_sect,
   output logic [7:0] sect,
   output logic [7:0] cyl_lo,
   output logic [7:0] cyl_hi,
   output logic [3:0] head
);
   logic [47:0] capped;

   // clamp to the 28-bit range, then pick lba or chs fields
   always_comb begin
      capped = (native_max > LBA28_CAP) ? LBA28_CAP : native_max;
      if (lba_mode) begin
         sect = capped[7:0];
         cyl_lo = capped[15:8];
         cyl_hi = capped[23:16];
         head = capped[27:24];
      end else begin
         sect = max_sect;
         cyl_lo = max_cyl[7:0];
         cyl_hi = max_cyl[15:8];
         head = max_head;
      end
   end
endmodule : ataln_natmax_fmt

/* File: logic/ataln_taskfile.sv */
// apb task-file block: extended read parameters, error address, native max report
`timescale 1ns/1ns

// Functional notes
// - The extended read length is 16 bits, low byte from the latest count write, high from the one before.
// - An assembled count of zero means 65,536 sectors are transferred.
// - After an error with high byte select clear, the three registers show error address bits 23:0.
// - After an error with high byte select set, the three registers show error address bits 47:24.
// - Command byte f8 asks for the native maximum address.
// - The native maximum reported ignores any reduced maximum set by software.
// - A native maximum beyond 28 bits is reported as 268,435,455.
// - In lba mode the sector register carries native max bits 7:0.
// - In lba mode cyl-low carries bits 15:8 and cyl-high bits 23:16.
// - In lba mode the head bits of device/head carry bits 27:24.
// - In chs mode sector, cylinder and head fields carry the maximum geometry instead.
module ataln_taskfile
   import ataln_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ataln_pkg::ADDR_W-1:0] paddr,
   input wire logic [ataln_pkg::DATA_W-1:0] pwdata,
   output logic [ataln_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic rd_start,
   output logic [47:0] rd_lba,
   output logic [16:0] rd_count,
   input wire logic rd_done,
   input wire logic rd_err,
   input wire logic [47:0] rd_err_lba
);
   ataln_state_t state_ff;
   logic [7:0] tf_cur_ff [TF_N];
   logic [7:0] tf_prev_ff [TF_N];
   logic [7:0] dev_cur [TF_N];
   logic [7:0] dev_prev [TF_N];
   logic [TF_N-1:0] host_wr;
   logic [TF_N-1:0] dev_ld;
   logic dev_ld_prev;
   logic [7:0] devhead_ff;
   logic hob_ff;
   logic [7:0] status_ff;
   logic [7:0] error_ff;
   logic [47:0] natmax_ff;
   logic [47:0] setmax_ff;
   logic [31:0] geometry_ff;
   logic [31:0] prdata_ff;
   logic pslverr_ff;
   logic rd_start_ff;
   logic [47:0] rd_lba_ff;
   logic [16:0] rd_count_ff;
   logic wr_en;
   logic setup;
   logic cmd_wr;
   logic nm_cmd;
   logic rd_cmd;
   logic rd_end;
   logic [47:0] start_lba;
   logic [15:0] raw_count;
   logic [16:0] xfer_count;
   logic [7:0] nm_sect;
   logic [7:0] nm_cyl_lo;
   logic [7:0] nm_cyl_hi;
   logic [3:0] nm_head;
   logic [31:0] rd_mux;
   logic rd_hit;

   // apb strobes: zero wait states, read data registered in the setup cycle, writes taken in the access cycle
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pwrite;
   assign pready = 1'b1;
   assign prdata = prdata_ff;
   assign pslverr = pslverr_ff;
   assign rd_start = rd_start_ff;
   assign rd_lba = rd_lba_ff;
   assign rd_count = rd_count_ff;

   // command decode; a command written while busy is dropped
   assign cmd_wr = wr_en & (paddr == OFF_CMD_STATUS) & (state_ff == ATALN_IDLE);
   assign nm_cmd = cmd_wr & (pwdata[7:0] == CMD_NATIVE_MAX);
   assign rd_cmd = cmd_wr & (pwdata[7:0] == CMD_READ_MULT_EXT);
   assign rd_end = (state_ff == ATALN_READ) & rd_done;

   // parameter assembly from current and previous bytes
   assign raw_count = {tf_prev_ff[TF_CNT], tf_cur_ff[TF_CNT]};
   assign xfer_count = (raw_count == 16'h0000) ? COUNT_ZERO_SECTORS : {1'b0, raw_count};
   assign start_lba = {tf_prev_ff[TF_CYLH], tf_prev_ff[TF_CYLL], tf_prev_ff[TF_SECT],
                       tf_cur_ff[TF_CYLH], tf_cur_ff[TF_CYLL], tf_cur_ff[TF_SECT]};

   // native max formatter works from the true capacity and geometry registers, never the reduced maximum
   ataln_natmax_fmt u_fmt (
      .native_max (natmax_ff),
      .lba_mode (devhead_ff[DEVHEAD_LBA_BIT]),
      .max_cyl (geometry_ff[GEO_CYL_LSB +: 16]),
      .max_head (geometry_ff[GEO_HEAD_LSB +: 4]),
      .max_sect (geometry_ff[GEO_SECT_LSB +: 8]),
      .sect (nm_sect),
      .cyl_lo (nm_cyl_lo),
      .cyl_hi (nm_cyl_hi),
      .head (nm_head)
   );

   // device-side loads into the task file: native max or error address
   always_comb begin
      dev_ld_prev = rd_end & rd_err;
      for (int i = 0; i < TF_N; i++) begin
         dev_cur[i] = tf_cur_ff[i];
         dev_prev[i] = tf_prev_ff[i];
         dev_ld[i] = 1'b0;
      end
      if (nm_cmd) begin
         dev_cur[TF_SECT] = nm_sect;
         dev_cur[TF_CYLL] = nm_cyl_lo;
         dev_cur[TF_CYLH] = nm_cyl_hi;
         dev_ld[TF_SECT] = 1'b1;
         dev_ld[TF_CYLL] = 1'b1;
         dev_ld[TF_CYLH] = 1'b1;
      end else if (dev_ld_prev) begin
         dev_cur[TF_SECT] = rd_err_lba[7:0];
         dev_cur[TF_CYLL] = rd_err_lba[15:8];
         dev_cur[TF_CYLH] = rd_err_lba[23:16];
         dev_prev[TF_SECT] = rd_err_lba[31:24];
         dev_prev[TF_CYLL] = rd_err_lba[39:32];
         dev_prev[TF_CYLH] = rd_err_lba[47:40];
         dev_ld[TF_SECT] = 1'b1;
         dev_ld[TF_CYLL] = 1'b1;
         dev_ld[TF_CYLH] = 1'b1;
      end
   end

   // task-file byte pairs: a host write shifts current into previous
   for (genvar gi = 0; gi < TF_N; gi++) begin : g_tf
      assign host_wr[gi] = wr_en & (paddr == OFF_SCOUNT + OFF_STEP * 8'(gi));
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            tf_cur_ff[gi] <= 8'h00;
            tf_prev_ff[gi] <= 8'h00;
         end else if (host_wr[gi]) begin
            tf_prev_ff[gi] <= tf_cur_ff[gi];
            tf_cur_ff[gi] <= pwdata[7:0];
         end else if (dev_ld[gi]) begin
            tf_cur_ff[gi] <= dev_cur[gi];
            if (dev_ld_prev) begin
               tf_prev_ff[gi] <= dev_prev[gi];
            end
         end
      end
   end

   // device/head: host write, head bits replaced by the native max report
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         devhead_ff <= 8'h00;
      end else if (wr_en & (paddr == OFF_DEVHEAD)) begin
         devhead_ff <= pwdata[7:0];
      end else if (nm_cmd) begin
         devhead_ff[3:0] <= nm_head;
      end
   end

   // high byte select: set by device control, cleared by a write to the count, sector or cylinder registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hob_ff <= 1'b0;
      end else if (wr_en & (paddr == OFF_DEVCTL)) begin
         hob_ff <= pwdata[DEVCTL_HOB_BIT];
      end else if (|host_wr) begin
         hob_ff <= 1'b0;
      end
   end

   // capacity configuration; the reduced maximum is held and read back but never used by the native max report
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         natmax_ff <= NATMAX_RESET;
         setmax_ff <= NATMAX_RESET;
         geometry_ff <= GEOMETRY_RESET;
      end else if (wr_en) begin
         if (paddr == OFF_NATMAX_LO) natmax_ff[31:0] <= pwdata;
         if (paddr == OFF_NATMAX_HI) natmax_ff[47:32] <= pwdata[15:0];
         if (paddr == OFF_SETMAX_LO) setmax_ff[31:0] <= pwdata;
         if (paddr == OFF_SETMAX_HI) setmax_ff[47:32] <= pwdata[15:0];
         if (paddr == OFF_GEOMETRY) geometry_ff <= pwdata;
      end
   end

   // command state, status and error registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ATALN_IDLE;
         status_ff <= STATUS_RESET;
         error_ff <= ERROR_NONE;
      end else if (nm_cmd) begin
         status_ff <= STATUS_OK;
         error_ff <= ERROR_NONE;
      end else if (rd_cmd) begin
         state_ff <= ATALN_READ;
         status_ff <= STATUS_BUSY;
         error_ff <= ERROR_NONE;
      end else if (cmd_wr) begin
         status_ff <= STATUS_FAIL; // unknown command aborts
         error_ff <= ERROR_ABORT;
      end else if (rd_end) begin
         state_ff <= ATALN_IDLE;
         status_ff <= rd_err ? STATUS_FAIL : STATUS_OK;
         error_ff <= rd_err ? ERROR_UNC : ERROR_NONE;
      end
   end

   // read request toward the media side, one-cycle start pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_start_ff <= 1'b0;
         rd_lba_ff <= 48'h0000_0000_0000;
         rd_count_ff <= 17'h0_0000;
      end else begin
         rd_start_ff <= rd_cmd;
         if (rd_cmd) begin
            rd_lba_ff <= start_lba;
            rd_count_ff <= xfer_count;
         end
      end
   end

   // read decode; task-file bytes follow the high byte select
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      unique case (paddr)
         OFF_FEATURE: rd_mux = 32'h0000_0000;
         OFF_SCOUNT: rd_mux[7:0] = hob_ff ? tf_prev_ff[TF_CNT] : tf_cur_ff[TF_CNT];
         OFF_SECT: rd_mux[7:0] = hob_ff ? tf_prev_ff[TF_SECT] : tf_cur_ff[TF_SECT];
         OFF_CYLL: rd_mux[7:0] = hob_ff ? tf_prev_ff[TF_CYLL] : tf_cur_ff[TF_CYLL];
         OFF_CYLH: rd_mux[7:0] = hob_ff ? tf_prev_ff[TF_CYLH] : tf_cur_ff[TF_CYLH];
         OFF_DEVHEAD: rd_mux[7:0] = devhead_ff;
         OFF_CMD_STATUS: rd_mux[7:0] = status_ff;
         OFF_ERROR: rd_mux[7:0] = error_ff;
         OFF_DEVCTL: rd_mux[DEVCTL_HOB_BIT] = hob_ff;
         OFF_NATMAX_LO: rd_mux = natmax_ff[31:0];
         OFF_NATMAX_HI: rd_mux[15:0] = natmax_ff[47:32];
         OFF_SETMAX_LO: rd_mux = setmax_ff[31:0];
         OFF_SETMAX_HI: rd_mux[15:0] = setmax_ff[47:32];
         OFF_GEOMETRY: rd_mux = geometry_ff;
         OFF_START_LO: rd_mux = start_lba[31:0];
         OFF_START_HI: rd_mux[15:0] = start_lba[47:32];
         OFF_XFER_CNT: rd_mux[16:0] = xfer_count;
         default: rd_hit = 1'b0;
      endcase
   end

   // apb answer registered during the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else if (setup) begin
         prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
         pslverr_ff <= ~rd_hit;
      end
   end

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic [23:0] err_lo;
   logic [23:0] err_hi;
   logic [27:0] tf_lba28;
   assign err_lo = rd_err_lba[23:0];
   assign err_hi = rd_err_lba[47:24];
   assign tf_lba28 = {devhead_ff[3:0], tf_cur_ff[TF_CYLH], tf_cur_ff[TF_CYLL], tf_cur_ff[TF_SECT]};

   a_count_pair: assert property (
      rd_cmd && raw_count != 16'h0000 |=> rd_count_ff == {1'b0, $past(raw_count)})
      else $error("read count not paired from current and previous bytes");
   a_count_zero: assert property (
      rd_cmd && raw_count == 16'h0000 |=> rd_count_ff == COUNT_ZERO_SECTORS && rd_start_ff)
      else $error("zero count did not become 65536 sectors");
   a_lba_assembly: assert property (
      rd_cmd |=> rd_lba_ff == $past(start_lba) && state_ff == ATALN_READ)
      else $error("start address misassembled");
   a_err_low: assert property (
      rd_end && rd_err |=> {tf_cur_ff[TF_CYLH], tf_cur_ff[TF_CYLL], tf_cur_ff[TF_SECT]}
         == $past(err_lo) && status_ff[ST_ERR])
      else $error("error address low bytes wrong");
   a_err_high: assert property (
      rd_end && rd_err |=> {tf_prev_ff[TF_CYLH], tf_prev_ff[TF_CYLL], tf_prev_ff[TF_SECT]}
         == $past(err_hi))
      else $error("error address high bytes wrong");
   a_nm_decode: assert property (
      nm_cmd |=> state_ff == ATALN_IDLE && !status_ff[ST_BSY] ##1 $stable(status_ff))
      else $error("native max command not completed");
   a_nm_lba: assert property (
      nm_cmd && devhead_ff[DEVHEAD_LBA_BIT] && natmax_ff <= LBA28_CAP
         |=> tf_lba28 == $past(natmax_ff[27:0]))
      else $error("native max not taken from true capacity");
   a_nm_clamp: assert property (
      nm_cmd && devhead_ff[DEVHEAD_LBA_BIT] && natmax_ff > LBA28_CAP
         |=> tf_lba28 == LBA28_CAP[27:0])
      else $error("native max not clamped to 28 bits");
   a_nm_chs: assert property (
      nm_cmd && !devhead_ff[DEVHEAD_LBA_BIT] |=> tf_cur_ff[TF_SECT] == geometry_ff[GEO_SECT_LSB +: 8]
         && devhead_ff[3:0] == geometry_ff[GEO_HEAD_LSB +: 4])
      else $error("chs maximum fields wrong");
   a_nm_status: assert property (
      nm_cmd |=> !status_ff[ST_BSY] && !status_ff[ST_DF] && !status_ff[ST_COR]
         && (error_ff & ~ERROR_ABORT) == 8'h00)
      else $error("native max status or error bits wrong");


   // command outcome, request pulse and read-back checks
   a_unknown_abort: assert property (
      cmd_wr && !nm_cmd && !rd_cmd |=> status_ff == STATUS_FAIL && error_ff == ERROR_ABORT)
      else $error("unknown command not aborted");
   a_count_range: assert property (
      rd_start_ff |-> rd_count_ff != 17'h0_0000 && rd_count_ff <= COUNT_ZERO_SECTORS)
      else $error("read count outside one to 65536 sectors");
   a_start_pulse: assert property (
      rd_start_ff |=> !rd_start_ff)
      else $error("read start longer than one cycle");
   a_nm_cyl_chs: assert property (
      nm_cmd && !devhead_ff[DEVHEAD_LBA_BIT]
         |=> {tf_cur_ff[TF_CYLH], tf_cur_ff[TF_CYLL]} == $past(geometry_ff[GEO_CYL_LSB +: 16]))
      else $error("chs maximum cylinder wrong");
   a_read_cur: assert property (
      setup && !pwrite && paddr == OFF_CYLL && !hob_ff
         |=> prdata_ff[7:0] == $past(tf_cur_ff[TF_CYLL]))
      else $error("current byte not read with high byte select clear");
   a_read_prev: assert property (
      setup && !pwrite && paddr == OFF_SECT && hob_ff
         |=> prdata_ff[7:0] == $past(tf_prev_ff[TF_SECT]))
      else $error("previous byte not read with high byte select set");

   c_nm_lba: cover property (nm_cmd && devhead_ff[DEVHEAD_LBA_BIT] && natmax_ff > LBA28_CAP);
   c_nm_chs: cover property (nm_cmd && !devhead_ff[DEVHEAD_LBA_BIT]);
   c_rd_err: cover property (rd_end && rd_err ##[1:100] hob_ff);
   c_rd_zero: cover property (rd_cmd && raw_count == 16'h0000);
   c_cmd_abort: cover property (cmd_wr && !nm_cmd && !rd_cmd);
endmodule : ataln_taskfile

/* File: shared/ataln_pkg.sv */
// shared constants, register map and types of the task-file command block
package ataln_pkg;
   // apb geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int TF_N = 4;
   // register byte addresses
   localparam logic [7:0] OFF_FEATURE = 8'h00;
   localparam logic [7:0] OFF_SCOUNT = 8'h04;
   localparam logic [7:0] OFF_SECT = 8'h08;
   localparam logic [7:0] OFF_CYLL = 8'h0c;
   localparam logic [7:0] OFF_CYLH = 8'h10;
   localparam logic [7:0] OFF_DEVHEAD = 8'h14;
   localparam logic [7:0] OFF_CMD_STATUS = 8'h18;
   localparam logic [7:0] OFF_ERROR = 8'h1c;
   localparam logic [7:0] OFF_DEVCTL = 8'h20;
   localparam logic [7:0] OFF_NATMAX_LO = 8'h24;
   localparam logic [7:0] OFF_NATMAX_HI = 8'h28;
   localparam logic [7:0] OFF_SETMAX_LO = 8'h2c;
   localparam logic [7:0] OFF_SETMAX_HI = 8'h30;
   localparam logic [7:0] OFF_GEOMETRY = 8'h34;
   localparam logic [7:0] OFF_START_LO = 8'h38;
   localparam logic [7:0] OFF_START_HI = 8'h3c;
   localparam logic [7:0] OFF_XFER_CNT = 8'h40;
   localparam logic [7:0] OFF_STEP = 8'h04;
   // task-file entry indices
   localparam int TF_CNT = 0;
   localparam int TF_SECT = 1;
   localparam int TF_CYLL = 2;
   localparam int TF_CYLH = 3;
   // command codes
   localparam logic [7:0] CMD_NATIVE_MAX = 8'hf8;
   localparam logic [7:0] CMD_READ_MULT_EXT = 8'h29;
   // status and error bit positions
   localparam int ST_BSY = 7;
   localparam int ST_RDY = 6;
   localparam int ST_DF = 5;
   localparam int ST_DSC = 4;
   localparam int ST_COR = 2;
   localparam int ST_ERR = 0;
   localparam int ER_UNC = 6;
   localparam int ER_ABT = 2;
   // status and error values
   localparam logic [7:0] STATUS_RESET = 8'h50;
   localparam logic [7:0] STATUS_OK = 8'h50;
   localparam logic [7:0] STATUS_BUSY = 8'h90;
   localparam logic [7:0] STATUS_FAIL = 8'h51;
   localparam logic [7:0] ERROR_NONE = 8'h00;
   localparam logic [7:0] ERROR_ABORT = 8'h04;
   localparam logic [7:0] ERROR_UNC = 8'h40;
   // field positions
   localparam int DEVCTL_HOB_BIT = 7;
   localparam int DEVHEAD_LBA_BIT = 6;
   localparam int GEO_CYL_LSB = 0;
   localparam int GEO_HEAD_LSB = 16;
   localparam int GEO_SECT_LSB = 20;
   // address and count limits
   localparam logic [47:0] LBA28_CAP = 48'h0000_0fff_ffff;
   localparam logic [16:0] COUNT_ZERO_SECTORS = 17'h1_0000;
   localparam logic [47:0] NATMAX_RESET = 48'h0000_0000_0000;
   localparam logic [31:0] GEOMETRY_RESET = 32'h0000_0000;
   typedef enum logic {ATALN_IDLE, ATALN_READ} ataln_state_t;
endpackage : ataln_pkg

/* File: verification/ataln_media_model.sv */
// behavioural media side that answers read requests of the task-file block
`timescale 1ns/1ns
module ataln_media_model
   import ataln_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic rd_start,
   input wire logic fail_en,
   input wire logic [47:0] fail_lba,
   input wire logic [7:0] delay,
   output logic rd_done,
   output logic rd_err,
   output logic [47:0] rd_err_lba
);
   import ataln_pkg::*;
   logic busy_ff;
   logic [7:0] cnt_ff;

   // wait delay cycles after a start, then finish with one done pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_ff <= 1'b0;
         cnt_ff <= 8'h00;
         rd_done <= 1'b0;
         rd_err <= 1'b0;
         rd_err_lba <= 48'h0;
      end else begin
         rd_done <= 1'b0;
         rd_err <= ~rd_err; // not valid outside done, so keep it moving
         rd_err_lba <= ~rd_err_lba;
         if (rd_start) begin
            busy_ff <= 1'b1;
            cnt_ff <= delay;
         end else if (busy_ff && cnt_ff == 8'h00) begin
            busy_ff <= 1'b0;
            rd_done <= 1'b1;
            rd_err <= fail_en;
            rd_err_lba <= fail_lba;
         end else if (busy_ff) begin
            cnt_ff <= cnt_ff - 8'h01;
         end
      end
   end
endmodule : ataln_media_model

/* File: verification/test_ata_lba48_params_native_max.sv */
// self-checking bench for the task-file command block
`timescale 1ns/1ns
module test_ata_lba48_params_native_max;
   import ataln_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_start, rd_done, rd_err;
   logic fail_en;
   logic [7:0] paddr, delay;
   logic [31:0] pwdata, prdata, q;
   logic [47:0] rd_lba, rd_err_lba, fail_lba, cap_lba;
   logic [16:0] rd_count, cap_cnt;
   int n_mismatch, samples_checked, n_start, s;

   ataln_taskfile DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rd_start(rd_start), .rd_lba(rd_lba), .rd_count(rd_count),
      .rd_done(rd_done), .rd_err(rd_err), .rd_err_lba(rd_err_lba));
   ataln_media_model media (.pclk(pclk), .presetn(presetn), .rd_start(rd_start),
      .fail_en(fail_en), .fail_lba(fail_lba), .delay(delay), .rd_done(rd_done),
      .rd_err(rd_err), .rd_err_lba(rd_err_lba));

   // clock
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // capture every read request as it leaves the block
   always @(posedge pclk) begin
      if (rd_start === 1'b1) begin
         n_start++;
         cap_lba = rd_lba;
         cap_cnt = rd_count;
      end
   end

   task chk_reg(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_reg

   task chk_wide(input logic [47:0] got, input logic [47:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_wide

   // one apb transfer, held until pready is seen high
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : xfer

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      xfer(1'b1, a, d, r, e);
   endtask : wr

   task rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      xfer(1'b0, a, 32'h0, r, e);
   endtask : rd

   // poll status until the read is no longer running
   task wait_idle;
      for (int i = 0; i < 64; i++) begin
         rd(OFF_CMD_STATUS, q);
         if (q[7:0] !== STATUS_BUSY) break;
      end
      // a read still running here means the poll limit ran out
      chk_reg({31'h0, q[7:0] === STATUS_BUSY}, 32'h0);
   endtask : wait_idle

   // sector, cylinder-low and cylinder-high bytes as one 24-bit value
   task chk_tf(input logic [23:0] exp);
      rd(OFF_SECT, q);
      chk_reg(q, {24'h0, exp[7:0]});
      rd(OFF_CYLL, q);
      chk_reg(q, {24'h0, exp[15:8]});
      rd(OFF_CYLH, q);
      chk_reg(q, {24'h0, exp[23:16]});
   endtask : chk_tf

   task chk_head(input logic [3:0] exp);
      rd(OFF_DEVHEAD, q);
      chk_reg({28'h0, q[3:0]}, {28'h0, exp});
   endtask : chk_head

   task t_reset;
      logic e;
      rd(OFF_CMD_STATUS, q);
      chk_reg(q, {24'h0, STATUS_RESET});
      rd(OFF_ERROR, q);
      chk_reg(q, 32'h0);
      wr(OFF_ERROR, 32'hff);
      rd(OFF_ERROR, q);
      chk_reg(q, 32'h0);
      xfer(1'b0, 8'hfc, 32'h0, q, e);
      chk_reg({31'h0, e}, 32'h1);
      chk_reg({31'h0, pready}, 32'h1);
      $display("t_reset done");
   endtask : t_reset

   task t_ext_read;
      wr(OFF_SCOUNT, 32'h12);
      wr(OFF_SCOUNT, 32'h34);
      wr(OFF_SECT, 32'h44);
      wr(OFF_SECT, 32'h11);
      wr(OFF_CYLL, 32'h55);
      wr(OFF_CYLL, 32'h22);
      wr(OFF_CYLH, 32'h66);
      wr(OFF_CYLH, 32'h33);
      s = n_start;
      wr(OFF_CMD_STATUS, {24'h0, CMD_READ_MULT_EXT});
      wait_idle();
      chk_reg(32'(n_start - s), 32'h1);
      chk_wide(cap_lba, 48'h6655_4433_2211);
      chk_wide(48'(cap_cnt), 48'h1234);
      chk_reg(q, {24'h0, STATUS_OK});
      rd(OFF_START_HI, q);
      chk_reg(q, 32'h0000_6655);
      $display("t_ext_read done");
   endtask : t_ext_read

   task t_zero_count;
      delay <= 8'd20;
      wr(OFF_SCOUNT, 32'h0);
      wr(OFF_SCOUNT, 32'h0);
      wr(OFF_CMD_STATUS, {24'h0, CMD_READ_MULT_EXT});
      rd(OFF_CMD_STATUS, q);
      chk_reg(q, {24'h0, STATUS_BUSY});
      // a command written while the read runs is dropped
      wr(OFF_CMD_STATUS, {24'h0, CMD_NATIVE_MAX});
      rd(OFF_CMD_STATUS, q);
      chk_reg(q, {24'h0, STATUS_BUSY});
      wait_idle();
      chk_wide(48'(cap_cnt), 48'h1_0000);
      rd(OFF_XFER_CNT, q);
      chk_reg(q, 32'h0001_0000);
      chk_wide(cap_lba, 48'h6655_4433_2211);
      $display("t_zero_count done");
   endtask : t_zero_count

   task t_err_addr;
      fail_en <= 1'b1;
      fail_lba <= 48'hc0ff_ee12_3456;
      delay <= 8'd3;
      wr(OFF_CMD_STATUS, {24'h0, CMD_READ_MULT_EXT});
      wait_idle();
      chk_reg(q, {24'h0, STATUS_FAIL});
      rd(OFF_ERROR, q);
      chk_reg(q, {24'h0, ERROR_UNC});
      wr(OFF_DEVCTL, 32'h00);
      chk_tf(24'h12_3456);
      wr(OFF_DEVCTL, 32'h80);
      chk_tf(24'hc0_ffee);
      wr(OFF_DEVCTL, 32'h00);
      fail_en <= 1'b0;
      $display("t_err_addr done");
   endtask : t_err_addr

   task t_native_lba;
      wr(OFF_NATMAX_LO, 32'h0abc_def1);
      wr(OFF_NATMAX_HI, 32'h0);
      wr(OFF_SETMAX_LO, 32'h100);
      wr(OFF_SETMAX_HI, 32'h0);
      wr(OFF_DEVHEAD, 32'h40);
      wr(OFF_CMD_STATUS, {24'h0, CMD_NATIVE_MAX});
      rd(OFF_CMD_STATUS, q);
      chk_reg(q, {24'h0, STATUS_OK});
      rd(OFF_ERROR, q);
      chk_reg(q, 32'h0);
      chk_tf(24'hbc_def1);
      chk_head(4'ha);
      wr(OFF_NATMAX_LO, 32'h2345_6789);
      wr(OFF_NATMAX_HI, 32'h1);
      wr(OFF_CMD_STATUS, {24'h0, CMD_NATIVE_MAX});
      chk_tf(24'hff_ffff);
      chk_head(4'hf);
      $display("t_native_lba done");
   endtask : t_native_lba

   task t_native_chs;
      wr(OFF_GEOMETRY, 32'h03ff_1234);
      wr(OFF_DEVHEAD, 32'h00);
      wr(OFF_CMD_STATUS, {24'h0, CMD_NATIVE_MAX});
      chk_tf(24'h12_343f);
      chk_head(4'hf);
      // any other command code aborts
      wr(OFF_CMD_STATUS, 32'h0);
      rd(OFF_CMD_STATUS, q);
      chk_reg(q, {24'h0, STATUS_FAIL});
      rd(OFF_ERROR, q);
      chk_reg(q, {24'h0, ERROR_ABORT});
      $display("t_native_chs done");
   endtask : t_native_chs

   task test_done;
      $display("counts: %0d compared, %0d mismatched", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done

   // reset, then the scenarios in order
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fail_en = 1'b0;
      fail_lba = 48'h0;
      delay = 8'h00;
      n_mismatch = 0;
      samples_checked = 0;
      n_start = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_ext_read();
      t_zero_count();
      t_err_addr();
      t_native_lba();
      t_native_chs();
      test_done();
   end

   // watchdog against a hung transfer
   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      test_done();
   end
endmodule : test_ata_lba48_params_native_max
